//--- rtl/rsc_core.sv
// Operation
// (RL1) setpoint is commanding variable times ratio factor plus basic offset
// (RL2) control difference is setpoint minus following variable, sent to core
// (RL3) ratio bounds writable only in structuring mode, range 0.0 to 9.999
// (RL4) after reset lower bound is zero, upper bound is one
// (RL5) basic offset writable in parameterization mode, -1.999 to 9.999, default 0
// (RL6) ratio factor is nominal ratio times bound span plus lower bound
// (RL7) actual ratio back-calculated, then normalized against the bounds
// (RL8) both process variables floored at 0.5 % for actual ratio only
// (RL9) normalized actual ratio goes to display and tracking output
// (RL10) no separate nominal ratio limit beyond factor bounds
// (RL11) key press advances both displays; level one shows both ratios
// (RL12) level two setpoint display shows manipulated variable
// (RL13) level three shows external ratio; actual display shows actual ratio
// (RL14) level four shows setpoint and following variable in percent
// (RL15) display order selector enables levels three and four
// (RL16) extension selector appends up to four setpoint display entries
// (RL17) linearized value replaces the assigned process variable
// (RL18) nominal source switching tracks inactive source, bumpless
// (RL19) nominal ratio saturated to zero..one before mapping
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module rsc_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [rsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic structuring_mode,
  input wire logic parameterization_mode,
  input wire logic signed [15:0] following_variable,
  input wire logic signed [15:0] commanding_variable,
  input wire logic signed [15:0] linearized_value,
  input wire logic signed [15:0] external_nominal_ratio,
  input wire logic external_select,
  input wire logic actual_tracking,
  input wire logic signed [15:0] manipulated_variable,
  input wire logic [63:0] extend_values,
  input wire logic level_key,
  output logic signed [15:0] setpoint,
  output logic signed [15:0] control_difference,
  output logic signed [15:0] tracking_value,
  output logic signed [15:0] sp_display,
  output logic signed [15:0] pv_display,
  output logic [2:0] display_level,
  output logic percent_format
);
  import rsc_pkg::*;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > SAT_MAX) begin
      return 16'sh7FFF;
    end else if (v < SAT_MIN) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction
  function automatic logic signed [15:0] mul_k(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b);
    return sat16(p / SCALE);
  endfunction
  function automatic logic in_range(input logic signed [15:0] v,
                                    input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction
  function automatic logic lvl_on(input logic [2:0] l, input logic [1:0] ord,
                                  input logic [2:0] ext);
    if (l == LVL_THREE) begin
      return ord[1];
    end else if (l == LVL_FOUR) begin
      return ord[0];
    end else if (l >= LVL_EXT0) begin
      return (l - LVL_EXT0) < ext;
    end
    return 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic signed [15:0] lower_r;
  logic signed [15:0] upper_r;
  logic signed [15:0] offset_r;
  logic [1:0] order_r;
  logic [2:0] extend_r;
  logic [1:0] lin_r;
  logic signed [15:0] nominal_r;
  logic signed [15:0] xv_r;
  logic signed [15:0] wdat;
  wire wr_lower = reg_wr && reg_addr == ADDR_LOWER;
  wire wr_upper = reg_wr && reg_addr == ADDR_UPPER;
  wire wr_offset = reg_wr && reg_addr == ADDR_OFFSET;
  wire wr_cfg = reg_wr && reg_addr == ADDR_CFG;
  wire wr_nom = reg_wr && reg_addr == ADDR_NOMINAL;
  wire [2:0] cfg_ext = reg_wdata[CFG_EXT_LSB +: 3];
  assign wdat = $signed(reg_wdata);
  wire ok_lower = structuring_mode && in_range(wdat, RATIO_MIN, RATIO_MAX); // RL3
  wire ok_offset = parameterization_mode && in_range(wdat, OFFSET_MIN, OFFSET_MAX); // RL5

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lower_r <= LOWER_RST; // RL4
      upper_r <= UPPER_RST; // RL4
      offset_r <= OFFSET_RST; // RL5
      order_r <= 2'h0;
      extend_r <= 3'h0;
      lin_r <= 2'h0;
    end else begin
      if (wr_lower && ok_lower) begin
        lower_r <= wdat; // RL3
      end
      if (wr_upper && ok_lower) begin
        upper_r <= wdat; // RL3
      end
      if (wr_offset && ok_offset) begin
        offset_r <= wdat; // RL5
      end
      if (wr_cfg && cfg_ext <= EXT_MAX) begin
        order_r <= reg_wdata[CFG_ORDER_LSB +: 2];
        extend_r <= cfg_ext;
        lin_r <= reg_wdata[CFG_LIN_LSB +: 2];
      end
    end
  end

  // tracking beats a software write so the inactive source never jumps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nominal_r <= NORM_ZERO;
    end else if (external_select) begin
      nominal_r <= external_nominal_ratio; // RL18
    end else if (actual_tracking) begin
      nominal_r <= xv_r; // RL9
    end else if (wr_nom) begin
      nominal_r <= wdat;
    end
  end

  logic [15:0] rd_val;
  always_comb begin
    if (reg_addr == ADDR_LOWER) begin
      rd_val = lower_r;
    end else if (reg_addr == ADDR_UPPER) begin
      rd_val = upper_r;
    end else if (reg_addr == ADDR_OFFSET) begin
      rd_val = offset_r;
    end else if (reg_addr == ADDR_CFG) begin
      rd_val = {9'h000, lin_r, extend_r, order_r};
    end else if (reg_addr == ADDR_NOMINAL) begin
      rd_val = nominal_r;
    end else if (reg_addr == ADDR_ACTUAL) begin
      rd_val = xv_r;
    end else if (reg_addr == ADDR_SETPOINT) begin
      rd_val = setpoint;
    end else begin
      rd_val = 16'h0000;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // ratio and setpoint datapath
  // ---------------------------------------------------------------
  logic signed [15:0] x1_r;
  logic signed [15:0] x2_r;
  logic signed [15:0] wv_r;
  logic signed [15:0] v_r;
  wire signed [15:0] x1_sel = (lin_r == LIN_X1) ? linearized_value : following_variable; // RL17
  wire signed [15:0] x2_sel = (lin_r == LIN_X2) ? linearized_value : commanding_variable; // RL17
  wire signed [15:0] wv_act = external_select ? external_nominal_ratio : nominal_r;
  // the only limit on the nominal ratio is the clamp to the unit span
  wire signed [15:0] wv_clip = wv_act < NORM_ZERO ? NORM_ZERO :
                               wv_act > NORM_ONE ? NORM_ONE : wv_act; // RL19 RL10
  wire signed [15:0] span = sat16(32'(upper_r) - 32'(lower_r));
  wire signed [15:0] v_nxt = sat16(32'(mul_k(wv_r, span)) + 32'(lower_r)); // RL6
  wire signed [15:0] w_nxt = sat16(32'(mul_k(v_r, x2_r)) + 32'(offset_r)); // RL1

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x1_r <= 16'sh0000;
      x2_r <= 16'sh0000;
      wv_r <= NORM_ZERO;
      v_r <= LOWER_RST;
      setpoint <= 16'sh0000;
      control_difference <= 16'sh0000;
    end else begin
      x1_r <= x1_sel;
      x2_r <= x2_sel;
      wv_r <= wv_clip;
      v_r <= v_nxt;
      setpoint <= w_nxt;
      control_difference <= sat16(32'(setpoint) - 32'(x1_r)); // RL2
    end
  end

  // ---------------------------------------------------------------
  // normalized actual ratio, two sequential divides
  // ---------------------------------------------------------------
  rsc_state_e state_r;
  logic div_start_r;
  logic signed [31:0] div_num_r;
  logic signed [15:0] div_den_r;
  logic div_done;
  logic signed [31:0] div_q;
  // floors only feed this path, the setpoint keeps the raw values
  wire signed [15:0] x1_lim = x1_r < PV_FLOOR ? PV_FLOOR : x1_r; // RL8
  wire signed [15:0] x2_lim = x2_r < PV_FLOOR ? PV_FLOOR : x2_r; // RL8
  wire signed [15:0] vis = sat16(div_q);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      div_start_r <= 1'b0;
      div_num_r <= 32'sh00000000;
      div_den_r <= 16'sh0000;
      xv_r <= 16'sh0000;
    end else begin
      div_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          div_num_r <= (32'(x1_lim) - 32'(offset_r)) * SCALE; // RL7
          div_den_r <= x2_lim;
          div_start_r <= 1'b1;
          state_r <= ST_DIV1;
        end
        ST_DIV1: begin
          if (div_done) begin
            div_num_r <= (32'(vis) - 32'(lower_r)) * SCALE; // RL7
            div_den_r <= span;
            div_start_r <= 1'b1;
            state_r <= ST_DIV2;
          end
        end
        ST_DIV2: begin
          if (div_done) begin
            // a non-positive span has no meaningful ratio
            xv_r <= span > 16'sh0000 ? sat16(div_q) : NORM_ZERO; // RL7
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  rsc_div u_div (
    .clk(clk),
    .reset_n(reset_n),
    .start(div_start_r),
    .num(div_num_r),
    .den(div_den_r),
    .done(div_done),
    .quot(div_q)
  );

  // ---------------------------------------------------------------
  // display levels
  // ---------------------------------------------------------------
  logic key1_r;
  logic key2_r;
  logic key3_r;
  logic key_state_r;
  logic [2:0] lvl_r;
  logic [2:0] lvl_nxt;
  wire key_stable = key2_r == key3_r;
  wire key_press = key_stable && key3_r && !key_state_r;
  always_comb begin
    lvl_nxt = LVL_ONE;
    for (int i = 7; i >= 1; i--) begin
      if (lvl_on(3'(lvl_r + 3'(i)), order_r, extend_r)) begin
        lvl_nxt = 3'(lvl_r + 3'(i)); // RL15 RL16
      end
    end
  end
  wire [1:0] ext_idx = 2'(lvl_r - LVL_EXT0);
  wire signed [15:0] ext_val = $signed(extend_values[16 * ext_idx +: 16]);
  logic signed [15:0] sp_sel;
  logic signed [15:0] pv_sel;
  always_comb begin
    pv_sel = xv_r; // RL13
    case (lvl_r)
      LVL_ONE: sp_sel = wv_act; // RL11
      LVL_TWO: sp_sel = manipulated_variable; // RL12
      LVL_THREE: sp_sel = external_nominal_ratio; // RL13
      LVL_FOUR: begin
        sp_sel = setpoint; // RL14
        pv_sel = x1_r; // RL14
      end
      default: sp_sel = ext_val; // RL16
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key1_r <= 1'b0;
      key2_r <= 1'b0;
      key3_r <= 1'b0;
      key_state_r <= 1'b0;
      lvl_r <= LVL_ONE;
      display_level <= LVL_ONE;
      sp_display <= 16'sh0000;
      pv_display <= 16'sh0000;
      percent_format <= 1'b0;
      tracking_value <= 16'sh0000;
    end else begin
      key1_r <= level_key;
      key2_r <= key1_r;
      key3_r <= key2_r;
      if (key_stable) begin
        key_state_r <= key3_r;
      end
      if (key_press) begin
        lvl_r <= lvl_nxt; // RL11
      end else if (!lvl_on(lvl_r, order_r, extend_r)) begin
        lvl_r <= LVL_ONE;
      end
      display_level <= lvl_r;
      sp_display <= sp_sel;
      pv_display <= pv_sel;
      percent_format <= lvl_r == LVL_FOUR; // RL14
      tracking_value <= xv_r; // RL9
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_bound_lock: assert property ((reg_wr && reg_addr == ADDR_LOWER && !structuring_mode) // RL3
    |=> $stable(lower_r)) else $error("lower bound changed outside structuring");
  chk_bound_range: assert property (in_range(upper_r, RATIO_MIN, RATIO_MAX)) // RL3
    else $error("upper bound out of range");
  chk_offset_write: assert property ((wr_offset && parameterization_mode // RL5
    && wdat == OFFSET_MIN) |=> offset_r == OFFSET_MIN) else $error("offset write lost");
  chk_factor_span: assert property (lower_r <= upper_r // RL19
    |=> v_r >= $past(lower_r) && v_r <= $past(upper_r)) else $error("ratio factor left bounds");
  chk_diff_value: assert property (control_difference == // RL2
    sat16(32'($past(setpoint)) - 32'($past(x1_r)))) else $error("control difference wrong");
  chk_setpoint_calc: assert property (setpoint == // RL1
    sat16(32'(mul_k($past(v_r), $past(x2_r))) + 32'($past(offset_r))))
    else $error("setpoint formula wrong");
  chk_floor_applied: assert property ((state_r == ST_IDLE && x2_r < PV_FLOOR) // RL8
    |=> div_den_r == PV_FLOOR) else $error("commanding floor missing");
  chk_track_out: assert property (tracking_value == $past(xv_r)) // RL9
    else $error("tracking value stale");
  chk_level_two: assert property (lvl_r == LVL_TWO // RL12
    |=> sp_display == $past(manipulated_variable)) else $error("level two wrong");
  chk_level_gate: assert property (order_r == 2'h0 && extend_r == 3'h0 // RL15
    |=> lvl_r <= LVL_TWO) else $error("disabled level shown");
  chk_pct_four: assert property (lvl_r == LVL_FOUR |=> percent_format // RL14
    && pv_display == $past(x1_r)) else $error("level four not percent");
  cov_key_step: cover property (key_press ##1 lvl_r == LVL_TWO);
  cov_xv_update: cover property (state_r == ST_DIV2 && div_done);
  cov_ext_level: cover property (lvl_r == LVL_EXT0);
  cov_locked_wr: cover property (wr_lower && !structuring_mode);
endmodule
`default_nettype wire

//--- rtl/rsc_div.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_div (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic signed [31:0] num,
  input wire logic signed [15:0] den,
  output logic done,
  output logic signed [31:0] quot
);
  // ---------------------------------------------------------------
  // restoring divide on magnitudes, one bit per clock
  // ---------------------------------------------------------------
  logic [31:0] q_r;
  logic [31:0] rem_r;
  logic [15:0] den_r;
  logic neg_r;
  logic [5:0] cnt_r;
  logic busy_r;
  logic [32:0] trial;
  logic [31:0] rem_sh;
  assign rem_sh = {rem_r[30:0], q_r[31]};
  assign trial = {1'b0, rem_sh} - {17'h00000, den_r};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_r <= 32'h00000000;
      rem_r <= 32'h00000000;
      den_r <= 16'h0000;
      neg_r <= 1'b0;
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      done <= 1'b0;
      quot <= 32'sh00000000;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        q_r <= num[31] ? 32'(-num) : num;
        den_r <= den[15] ? 16'(-den) : den;
        neg_r <= num[31] ^ den[15];
        rem_r <= 32'h00000000;
        cnt_r <= 6'h20;
        busy_r <= 1'b1;
      end else if (busy_r && cnt_r != 6'h00) begin
        rem_r <= trial[32] ? rem_sh : trial[31:0];
        q_r <= {q_r[30:0], ~trial[32]};
        cnt_r <= cnt_r - 6'h01;
      end else if (busy_r) begin
        // zero divisor gives the largest magnitude, not garbage
        if (den_r == 16'h0000) begin
          quot <= neg_r ? -32'sh7FFFFFFF : 32'sh7FFFFFFF;
        end else begin
          quot <= neg_r ? -$signed(q_r) : $signed(q_r);
        end
        done <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/rsc_pkg.sv
package rsc_pkg;
  // ---------------------------------------------------------------
  // number format: signed, 1.000 = 1000, 100.0 % = 1000
  // ---------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int ADDR_W = 3;
  localparam logic signed [31:0] SCALE = 32'sd1000;
  localparam logic signed [31:0] SAT_MAX = 32'sd32767;
  localparam logic signed [31:0] SAT_MIN = -32'sd32768;
  localparam logic signed [15:0] RATIO_MIN = 16'sh0000;
  localparam logic signed [15:0] RATIO_MAX = 16'sh270F;
  localparam logic signed [15:0] OFFSET_MIN = -16'sh07CF;
  localparam logic signed [15:0] OFFSET_MAX = 16'sh270F;
  localparam logic signed [15:0] NORM_ONE = 16'sh03E8;
  localparam logic signed [15:0] NORM_ZERO = 16'sh0000;
  // 0.5 % floor in units of 0.1 %
  localparam logic signed [15:0] PV_FLOOR = 16'sh0005;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic signed [15:0] LOWER_RST = 16'sh0000;
  localparam logic signed [15:0] UPPER_RST = 16'sh03E8;
  localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
  // ---------------------------------------------------------------
  // register map and config fields
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_LOWER = 3'h0;
  localparam logic [2:0] ADDR_UPPER = 3'h1;
  localparam logic [2:0] ADDR_OFFSET = 3'h2;
  localparam logic [2:0] ADDR_CFG = 3'h3;
  localparam logic [2:0] ADDR_NOMINAL = 3'h4;
  localparam logic [2:0] ADDR_ACTUAL = 3'h5;
  localparam logic [2:0] ADDR_SETPOINT = 3'h6;
  localparam int CFG_ORDER_LSB = 0;
  localparam int CFG_EXT_LSB = 2;
  localparam int CFG_LIN_LSB = 5;
  localparam logic [2:0] EXT_MAX = 3'h4;
  localparam logic [1:0] LIN_X1 = 2'h1;
  localparam logic [1:0] LIN_X2 = 2'h2;
  // ---------------------------------------------------------------
  // display levels in rotation order
  // ---------------------------------------------------------------
  localparam logic [2:0] LVL_ONE = 3'h0;
  localparam logic [2:0] LVL_TWO = 3'h1;
  localparam logic [2:0] LVL_THREE = 3'h2;
  localparam logic [2:0] LVL_FOUR = 3'h3;
  localparam logic [2:0] LVL_EXT0 = 3'h4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV1 = 2'b01,
    ST_DIV2 = 2'b10
  } rsc_state_e;
endpackage

//--- verif/ratio_setpoint_calc_test.sv
`timescale 1ns/1ps
`default_nettype none
module ratio_setpoint_calc_test;
  import rsc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic smode = 1'b0;
  logic pmode = 1'b0;
  logic signed [15:0] x1 = 16'h012C;
  logic signed [15:0] x2 = 16'h0190;
  logic signed [15:0] lin_val = 16'h0320;
  logic signed [15:0] ext_nr = 16'h0309;
  logic ext_sel = 1'b0;
  logic trk = 1'b0;
  logic signed [15:0] mv = 16'h0141;
  logic [63:0] ext_vals = 64'h0D04_0C03_0B02_0A01;
  logic press = 1'b0;
  logic level_key;
  logic signed [15:0] setpoint, control_difference, tracking_value, sp_display, pv_display;
  logic [2:0] display_level;
  logic percent_format;
  logic [2:0] e, lv;
  int fails = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  rsc_core dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .structuring_mode(smode),
    .parameterization_mode(pmode), .following_variable(x1), .commanding_variable(x2),
    .linearized_value(lin_val), .external_nominal_ratio(ext_nr), .external_select(ext_sel),
    .actual_tracking(trk), .manipulated_variable(mv), .extend_values(ext_vals),
    .level_key(level_key), .setpoint(setpoint), .control_difference(control_difference),
    .tracking_value(tracking_value), .sp_display(sp_display), .pv_display(pv_display),
    .display_level(display_level), .percent_format(percent_format));

  rsc_panel panel_u (.clk(clk), .press(press), .level_key(level_key), .busy());

  // ---------------------------------------------------------------
  // bus, key and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic press_key;
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    settle(16);
  endtask

  // next enabled level in rotation order, wrapping to level one
  function automatic logic [2:0] nxt(input logic [2:0] l, input logic [1:0] o, input logic [2:0] x);
    logic [2:0] n;
    n = l;
    for (int i = 0; i < 8; i++) begin
      n = n + 3'h1;
      if (n < 3'h2 || (n == 3'h2 && o[1]) || (n == 3'h3 && o[0])) return n;
      if ({1'b0, n} >= 4'h4 && {1'b0, n} < 4'h4 + {1'b0, x}) return n;
    end
    return 3'h0;
  endfunction

  function automatic logic [15:0] exp_sp(input logic [2:0] l);
    case (l)
      LVL_ONE: return 16'h0258;
      LVL_TWO: return mv;
      LVL_THREE: return ext_nr;
      LVL_FOUR: return 16'h021C;
      default: return ext_vals[16 * (l - 3'h4) +: 16];
    endcase
  endfunction

  task automatic end_of_test;
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    chk("display_level", 16'h0000, {13'h0, display_level});
    rd_chk("lower", ADDR_LOWER, 16'h0000);
    rd_chk("upper", ADDR_UPPER, 16'h03E8);
    rd_chk("offset", ADDR_OFFSET, 16'h0000);
    rd_chk("unmapped", 3'h7, 16'h0000);
    // locked writes first, then range limits with the mode open
    wr_reg(ADDR_UPPER, 16'h07D0);
    wr_reg(ADDR_LOWER, 16'h0064);
    rd_chk("upper", ADDR_UPPER, 16'h03E8);
    rd_chk("lower", ADDR_LOWER, 16'h0000);
    smode <= 1'b1;
    wr_reg(ADDR_UPPER, 16'h2710);
    rd_chk("upper", ADDR_UPPER, 16'h03E8);
    wr_reg(ADDR_LOWER, 16'h01F4);
    wr_reg(ADDR_UPPER, 16'h05DC);
    rd_chk("lower", ADDR_LOWER, 16'h01F4);
    rd_chk("upper", ADDR_UPPER, 16'h05DC);
    smode <= 1'b0;
    wr_reg(ADDR_OFFSET, 16'h0064);
    rd_chk("offset", ADDR_OFFSET, 16'h0000);
    pmode <= 1'b1;
    wr_reg(ADDR_OFFSET, 16'hF830);
    rd_chk("offset", ADDR_OFFSET, 16'h0000);
    wr_reg(ADDR_OFFSET, 16'hF831);
    rd_chk("offset", ADDR_OFFSET, 16'hF831);
    wr_reg(ADDR_OFFSET, 16'h0064);
    rd_chk("offset", ADDR_OFFSET, 16'h0064);
    pmode <= 1'b0;
    // factor 1.1 times 40.0 % plus 0.1 gives 54.0 %
    wr_reg(ADDR_NOMINAL, 16'h0258);
    settle(150);
    chk("setpoint", 16'h021C, setpoint);
    chk("control_difference", 16'h00F0, control_difference);
    rd_chk("setpoint_reg", ADDR_SETPOINT, 16'h021C);
    chk("tracking_value", 16'h0000, tracking_value);
    x1 <= 16'h02BC;
    settle(150);
    chk("control_difference", 16'hFF60, control_difference);
    chk("tracking_value", 16'h03E8, tracking_value);
    rd_chk("actual_reg", ADDR_ACTUAL, 16'h03E8);
    wr_reg(ADDR_CFG, {9'h000, 2'h0, 3'h5, 2'h3});
    rd_chk("cfg", ADDR_CFG, 16'h0000);
    // every order setting with a growing extension
    for (int o = 0; o < 4; o++) begin
      e = (o == 3) ? EXT_MAX : 3'(o);
      wr_reg(ADDR_CFG, {9'h000, 2'h0, e, 2'(o)});
      lv = LVL_ONE;
      repeat (2 + o[0] + o[1] + e) begin
        lv = nxt(lv, 2'(o), e);
        press_key();
        chk("display_level", {13'h0, lv}, {13'h0, display_level});
        chk("sp_display", exp_sp(lv), sp_display);
        chk("pv_display", (lv == LVL_FOUR) ? 16'h02BC : 16'h03E8, pv_display);
        chk("percent_format", {15'h0, lv == LVL_FOUR}, {15'h0, percent_format});
      end
    end
    // nominal above one is clipped, factor stops at the upper bound
    wr_reg(ADDR_NOMINAL, 16'h04B0);
    settle(20);
    chk("setpoint", 16'h02BC, setpoint);
    wr_reg(ADDR_CFG, {9'h000, LIN_X2, 3'h0, 2'h0});
    settle(20);
    chk("setpoint", 16'h0514, setpoint);
    wr_reg(ADDR_CFG, {9'h000, LIN_X1, 3'h0, 2'h0});
    settle(20);
    chk("control_difference", 16'hFF9C, control_difference);
    wr_reg(ADDR_CFG, 16'h0000);
    // negative commanding variable must not flip the ratio sign
    x2 <= 16'hFFEC;
    x1 <= 16'h0069;
    settle(200);
    chk("tracking_value", 16'h01F4, tracking_value);
    trk <= 1'b1;
    settle(10);
    wr_reg(ADDR_NOMINAL, 16'h0064);
    settle(10);
    rd_chk("nominal", ADDR_NOMINAL, 16'h01F4);
    trk <= 1'b0;
    ext_sel <= 1'b1;
    x2 <= 16'h0190;
    settle(10);
    chk("setpoint", 16'h0262, setpoint);
    chk("sp_display", 16'h0309, sp_display);
    rd_chk("nominal", ADDR_NOMINAL, 16'h0309);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verif/rsc_panel.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// front panel shift key with contact hold and release time
// ---------------------------------------------------------------
module rsc_panel (
  input wire logic clk,
  input wire logic press,
  output logic level_key,
  output logic busy
);
  int cnt = 0;
  // held high six cycles then low six more, so one push is seen once
  // and the next push keeps the minimum low time
  always @(posedge clk) begin
    if (cnt == 0 && press) begin
      cnt <= 12;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign level_key = (cnt > 6);
  assign busy = (cnt != 0) || press;
endmodule
`default_nettype wire
